// file: logic_cluster_defines.svh
`ifndef LOGIC_CLUSTER_DEFINES_SVH
`define LOGIC_CLUSTER_DEFINES_SVH

`define LC_NUM_CELLS          10
`define LC_NUM_ROW_CLK        8
`define LC_ADDR_W             8
`define LC_ADDR_CTRL          8'h00
`define LC_ADDR_REG_STATE     8'h04
`define LC_ADDR_LUT_STATE     8'h08
`define LC_ADDR_CELL_BASE     8'h40
`define LC_CELL_WORD_BASE     6'h10
`define LC_CTRL_RESET         32'h0000_0000
`define LC_CELL_CFG_RESET     32'h0000_0000
`define LC_CTRL_SEL_A_LSB     0
`define LC_CTRL_SEL_B_LSB     3
`define LC_CTRL_FALL_B_BIT    6
`define LC_CTRL_CHIPRST_BIT   7
`define LC_CTRL_MASK          32'h0000_00FF
`define LC_AXI_OKAY           2'h0
`define LC_AXI_SLVERR         2'h2

`endif

// file: logic_cluster_pkg.sv
`default_nettype none
package logic_cluster_pkg;

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_mode_t;

  // one cell configuration word, bit 31 down to bit 0
  typedef struct packed {
    logic [3:0]  spare;
    logic        arith;
    logic        reg_chain;
    logic        lut_chain;
    logic        local_in;
    logic [2:0]  out_reg;
    logic        pack_fb;
    logic        clr_sel_b;
    logic        clk_sel_b;
    logic [1:0]  ff_mode;
    logic [15:0] lut_mask;
  } cell_cfg_t;

  // cluster controls arriving from local routing, all active high
  typedef struct packed {
    logic gate_a;
    logic gate_b;
    logic clr_a;
    logic clr_b;
    logic sclr;
    logic aload;
    logic sload;
    logic addnsub;
  } cluster_ctl_t;

endpackage
`default_nettype wire

// file: logic_cluster.sv
`include "logic_cluster_defines.svh"
`default_nettype none

// How it works
// R1 - ten cells with carry, controls, local routing, lookup and register chains
// R2 - lookup chain feeds one cell's lookup result into the next cell's lookup
// R3 - register chain feeds one cell's register into the next cell's register
// R4 - at most ten controls: two clocks, two gates, two clears, four others
// R5 - each cluster clock has its own paired clock gate
// R6 - both-edge use takes clock a on rising and clock b on falling edge
// R7 - a low clock gate stops every register on that clock
// R8 - async load copies load data; high load data acts as preset
// R9 - cluster clocks are picked from eight row clocks plus local controls; here only from the eight row clocks
// R10 - each cell has a sixteen-entry lookup for any four-input function
// R11 - register works as D, T, JK or SR flip-flop
// R12 - register has data, load data, clock, gate, clear and load inputs
// R13 - async load data comes from cell input d
// R14 - combinational use bypasses the register to the outputs
// R15 - three outputs each pick lookup or register: two routing, one local
// R16 - packing option feeds the register back into its own lookup
// R17 - registered and unregistered lookup result may show together
// R18 - lookups do one function while registers shift through the chain
// R19 - subtract inverts every b bit and forces first carry in to one
// R20 - the far side maps the adder's least significant bit to cell zero
// R21 - each cell reaches other cells by local and direct-link routing; here only by local routing
// R22 - local routing takes routing, own cells and neighbour direct links; here only routing and the next cell's local output
// R23 - clear beats async load when both are active
// R24 - enabled chip-wide reset clears every register above all else
// R25 - sync clear and load act on gated edges, clear before load
module logic_cluster
  import logic_cluster_pkg::*;
#(
  parameter int unsigned NUM_CELLS = `LC_NUM_CELLS
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_b,
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [`LC_ADDR_W-1:0]       i_awaddr,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  output logic [1:0]                       o_bresp,
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  input  wire logic [`LC_ADDR_W-1:0]       i_araddr,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  output logic [31:0]                      o_rdata,
  output logic [1:0]                       o_rresp,
  input  wire logic [`LC_NUM_ROW_CLK-1:0]  i_row_clk,
  input  wire cluster_ctl_t                i_ctl,
  input  wire logic                        i_chip_wide_reset_n,
  input  wire logic [NUM_CELLS-1:0][3:0]   i_cell_data,
  output logic [NUM_CELLS-1:0]             o_cell_row_a,
  output logic [NUM_CELLS-1:0]             o_cell_row_b,
  output logic [NUM_CELLS-1:0]             o_cell_local,
  output logic                             o_lut_chain_out,
  output logic                             o_reg_chain_out,
  output logic                             o_carry_out
);

  logic [1:0]                 rst_sync_q;
  logic                       rst_n;
  logic [31:0]                ctrl_q;
  cell_cfg_t                  cfg_q [NUM_CELLS];
  logic [NUM_CELLS-1:0]       reg_q;
  logic [NUM_CELLS-1:0]       reg_d;
  logic [NUM_CELLS:0]         lut_w;
  logic [NUM_CELLS:0]         regc_w;
  logic [NUM_CELLS:0]         car_w;
  logic [NUM_CELLS-1:0]       row_a_w;
  logic [NUM_CELLS-1:0]       row_b_w;
  logic [NUM_CELLS-1:0]       loc_w;
  logic [`LC_NUM_ROW_CLK-1:0] row_prev_q;
  logic [2:0]                 sel_a;
  logic [2:0]                 sel_b;
  logic                       ev_a;
  logic                       ev_b;
  logic                       chip_rst;
  logic                       aw_got_q;
  logic                       w_got_q;
  logic [`LC_ADDR_W-1:0]      aw_addr_q;
  logic [31:0]                w_data_q;
  logic [3:0]                 w_strb_q;
  logic                       wr_fire;
  logic [5:0]                 wr_idx;
  logic [5:0]                 rd_idx;
  logic [31:0]                rd_data_w;
  logic                       rd_err_w;

  // reset release through two flops
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // cluster clocks: row clock edges turned into gated one-cycle events
  assign sel_a    = ctrl_q[`LC_CTRL_SEL_A_LSB +: 3];                                   // [R9] [R4]
  assign sel_b    = ctrl_q[`LC_CTRL_SEL_B_LSB +: 3];                                   // [R9]
  assign ev_a     = i_row_clk[sel_a] & ~row_prev_q[sel_a] & i_ctl.gate_a;              // [R5] [R7]
  assign ev_b     = (ctrl_q[`LC_CTRL_FALL_B_BIT] ? (~i_row_clk[sel_b] & row_prev_q[sel_b])
                                                 : (i_row_clk[sel_b] & ~row_prev_q[sel_b]))
                    & i_ctl.gate_b;                                                    // [R6] [R5] [R7]
  assign chip_rst = ctrl_q[`LC_CTRL_CHIPRST_BIT] & ~i_chip_wide_reset_n;               // [R24]

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      row_prev_q <= '0;
    end else begin
      row_prev_q <= i_row_clk;
    end
  end

  // register next state, priority low to high: mode, sync, async load, clear, chip reset
  function automatic logic ff_next(input logic q, input logic d, input logic k, input logic ev,
                                   input logic sclr, input logic sload, input logic aload,
                                   input logic adata, input logic clr, input logic rst,
                                   input logic [1:0] mode);
    logic n;
    n = q;
    if (ev) begin
      if (sclr) begin                                                                  // [R25]
        n = 1'b0;
      end else if (sload) begin
        n = k;
      end else begin
        case (ff_mode_t'(mode))                                                        // [R11]
          FF_D:    n = d;
          FF_T:    n = q ^ d;
          FF_JK:   n = (d & ~q) | (~k & q);
          FF_SR:   n = d | (~k & q);
          default: n = d;
        endcase
      end
    end
    if (aload) begin
      n = adata;                                                                       // [R8] [R13]
    end
    if (clr) begin
      n = 1'b0;                                                                        // [R23]
    end
    if (rst) begin
      n = 1'b0;                                                                        // [R24]
    end
    return n;
  endfunction

  assign lut_w[0]  = 1'b0;
  assign regc_w[0] = 1'b0;
  assign car_w[0]  = i_ctl.addnsub;                                                    // [R19]

  // one slice per cell
  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell                                // [R1]
    cell_cfg_t  cfg;
    logic       in0;
    logic       in1;
    logic       in3;
    logic       b_eff;
    logic       lut_val;
    logic       fd;
    assign cfg     = cfg_q[i];
    assign in0     = cfg.lut_chain ? lut_w[i] : i_cell_data[i][0];                     // [R2]
    assign in1     = cfg.local_in ? o_cell_local[(i + 1) % NUM_CELLS]
                                  : i_cell_data[i][1];                                 // [R21] [R22]
    assign in3     = cfg.pack_fb ? reg_q[i] : i_cell_data[i][3];                       // [R16]
    assign b_eff   = in1 ^ i_ctl.addnsub;                                              // [R19]
    assign lut_val = cfg.arith ? (in0 ^ b_eff ^ car_w[i])
                               : cfg.lut_mask[{in3, i_cell_data[i][2], in1, in0}];     // [R10]
    assign car_w[i+1] = cfg.arith ? ((in0 & b_eff) | (car_w[i] & (in0 ^ b_eff)))
                                  : i_ctl.addnsub;
    assign lut_w[i+1] = lut_val;                                                       // [R2]
    assign fd      = cfg.reg_chain ? regc_w[i] : lut_val;                              // [R3] [R18]
    assign regc_w[i+1] = reg_q[i];
    assign reg_d[i] = ff_next(reg_q[i], fd, i_cell_data[i][2],
                              cfg.clk_sel_b ? ev_b : ev_a,
                              i_ctl.sclr, i_ctl.sload, i_ctl.aload, i_cell_data[i][3],
                              cfg.clr_sel_b ? i_ctl.clr_b : i_ctl.clr_a, chip_rst,
                              cfg.ff_mode);                                            // [R12]
    assign row_a_w[i] = cfg.out_reg[0] ? reg_q[i] : lut_val;                           // [R15] [R14] [R17]
    assign row_b_w[i] = cfg.out_reg[1] ? reg_q[i] : lut_val;                           // [R15] [R17]
    assign loc_w[i]   = cfg.out_reg[2] ? reg_q[i] : lut_val;                           // [R15]
  end

  // cell registers
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_q <= '0;
    end else begin
      reg_q <= reg_d;
    end
  end

  // cell outputs
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_cell_row_a    <= '0;
      o_cell_row_b    <= '0;
      o_cell_local    <= '0;
      o_lut_chain_out <= 1'b0;
      o_reg_chain_out <= 1'b0;
      o_carry_out     <= 1'b0;
    end else begin
      o_cell_row_a    <= row_a_w;
      o_cell_row_b    <= row_b_w;
      o_cell_local    <= loc_w;
      o_lut_chain_out <= lut_w[NUM_CELLS];                                             // [R2]
      o_reg_chain_out <= reg_q[NUM_CELLS-1];                                           // [R3]
      o_carry_out     <= car_w[NUM_CELLS];
    end
  end

  // bus write channels
  assign wr_fire = aw_got_q & w_got_q & ~o_bvalid;
  assign wr_idx  = aw_addr_q[7:2] - `LC_CELL_WORD_BASE;
  assign rd_idx  = i_araddr[7:2] - `LC_CELL_WORD_BASE;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `LC_AXI_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        aw_got_q  <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        w_got_q  <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= (aw_addr_q == `LC_ADDR_CTRL ||
                     (aw_addr_q[1:0] == 2'h0 && aw_addr_q >= `LC_ADDR_CELL_BASE &&
                      wr_idx < 6'(NUM_CELLS))) ? `LC_AXI_OKAY : `LC_AXI_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // writable registers
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `LC_CTRL_RESET;
      for (int c = 0; c < NUM_CELLS; c++) begin
        cfg_q[c] <= cell_cfg_t'(`LC_CELL_CFG_RESET);
      end
    end else if (wr_fire) begin
      if (aw_addr_q == `LC_ADDR_CTRL) begin
        ctrl_q <= strb_merge(ctrl_q, w_data_q, w_strb_q) & `LC_CTRL_MASK;
      end
      for (int c = 0; c < NUM_CELLS; c++) begin
        if (aw_addr_q[1:0] == 2'h0 && aw_addr_q >= `LC_ADDR_CELL_BASE && wr_idx == 6'(c)) begin
          cfg_q[c] <= cell_cfg_t'(strb_merge(32'(cfg_q[c]), w_data_q, w_strb_q));
        end
      end
    end
  end

  // read decode
  always_comb begin
    rd_data_w = 32'h0000_0000;
    rd_err_w  = 1'b0;
    if (i_araddr == `LC_ADDR_CTRL) begin
      rd_data_w = ctrl_q;
    end else if (i_araddr == `LC_ADDR_REG_STATE) begin
      rd_data_w = 32'(reg_q);
    end else if (i_araddr == `LC_ADDR_LUT_STATE) begin
      rd_data_w = 32'(lut_w[NUM_CELLS:1]);
    end else if (i_araddr[1:0] == 2'h0 && i_araddr >= `LC_ADDR_CELL_BASE &&
                 rd_idx < 6'(NUM_CELLS)) begin
      rd_data_w = 32'(cfg_q[rd_idx[3:0]]);
    end else begin
      rd_err_w = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `LC_AXI_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_data_w;
      o_rresp   <= rd_err_w ? `LC_AXI_SLVERR : `LC_AXI_OKAY;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_wr_both;
    aw_got_q && w_got_q && !o_bvalid;
  endsequence
  sequence s_resp_up;
    o_bvalid && !o_awready && !o_wready;
  endsequence

  a_write_resp_follows: assert property (s_wr_both |=> s_resp_up)
    else $error("write response missing");
  a_read_data_follows: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read data missing");
  a_subtract_carry_in: assert property (i_ctl.addnsub && cfg_q[0].arith && !cfg_q[0].lut_chain && // [R19]
                                        !cfg_q[0].local_in |-> lut_w[1] == (i_cell_data[0][0] ^ i_cell_data[0][1]))
    else $error("subtract carry in not one");
  a_clear_beats_load: assert property (i_ctl.aload && !cfg_q[0].clr_sel_b && i_ctl.clr_a
                                       |=> !reg_q[0])                                  // [R23]
    else $error("clear lost to async load");
  a_chip_reset_clears: assert property (chip_rst |=> reg_q == '0)                      // [R24]
    else $error("chip reset left a register set");
  a_async_load_data: assert property (i_ctl.aload && !i_ctl.clr_a && !i_ctl.clr_b && !chip_rst
                                      |=> reg_q[0] == $past(i_cell_data[0][3]))        // [R8]
    else $error("async load data not taken");
  a_gate_stops_clock: assert property (!i_ctl.gate_a && !cfg_q[0].clk_sel_b && !i_ctl.aload &&
                                       !i_ctl.clr_a && !i_ctl.clr_b && !chip_rst
                                       |=> $stable(reg_q[0]))                          // [R7]
    else $error("register moved with gate low");
  a_reg_chain_shift: assert property (ev_a && !cfg_q[1].clk_sel_b && cfg_q[1].reg_chain &&
                                      cfg_q[1].ff_mode == 2'h0 && !i_ctl.sclr && !i_ctl.sload &&
                                      !i_ctl.aload && !i_ctl.clr_a && !i_ctl.clr_b && !chip_rst
                                      |=> reg_q[1] == $past(reg_q[0]))                 // [R3]
    else $error("register chain did not shift");
  a_sync_clear_first: assert property (ev_a && !cfg_q[0].clk_sel_b && i_ctl.sclr && i_ctl.sload &&
                                       !i_ctl.aload && !chip_rst |=> !reg_q[0])        // [R25]
    else $error("sync clear lost to sync load");
  a_lut_chain_out: assert property (##1 o_lut_chain_out == $past(lut_w[NUM_CELLS]))    // [R2]
    else $error("lookup chain output wrong");

endmodule
`default_nettype wire

// file: row_clock_source.sv
`default_nettype none
module row_clock_source (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_req,
  input  wire logic [2:0] i_row,
  input  wire logic       i_slow,
  output logic [7:0]      o_row_clk,
  output logic            o_done
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] wait_q;

  // row clocks stand still between requests; each request flips one row
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_row_clk <= 8'h00;
      wait_q    <= 3'h0;
      o_done    <= 1'b0;
    end else if (!i_req || o_done) begin
      wait_q <= 3'h0;
      o_done <= 1'b0;
    end else if (wait_q == (i_slow ? 3'h4 : 3'h0)) begin
      o_row_clk[i_row] <= ~o_row_clk[i_row];
      o_done           <= 1'b1;
    end else begin
      wait_q <= wait_q + 3'h1;
    end
  end
endmodule
`default_nettype wire

// file: logic_cluster_bench.sv
`include "logic_cluster_defines.svh"
`default_nettype none
module logic_cluster_bench import logic_cluster_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [1:0] OK = `LC_AXI_OKAY;
  localparam logic [1:0] ER = `LC_AXI_SLVERR;
  logic            clk = 1'b0;
  logic            rst_b = 1'b0;
  logic            awvalid = 1'b0;
  logic            wvalid = 1'b0;
  logic            arvalid = 1'b0;
  logic [7:0]      awaddr = 8'h00;
  logic [7:0]      araddr = 8'h00;
  logic [31:0]     wdata = 32'h0;
  logic            req = 1'b0;
  logic            slow = 1'b0;
  logic            chip_rst_n = 1'b1;
  logic [2:0]      row = 3'h0;
  cluster_ctl_t    ctl = '0;
  logic [9:0][3:0] dat = '0;
  logic            awready, wready, bvalid, arready, rvalid, done, lco, rco, co;
  logic [1:0]      bresp, rresp;
  logic [31:0]     rdata;
  logic [7:0]      row_clk;
  logic [9:0]      row_a, row_b, loc;
  logic [9:0]      e1 [4] = '{10'h3FF, 10'h0, 10'h0, 10'h3FF};
  logic [9:0]      e2 [4] = '{10'h0, 10'h0, 10'h0, 10'h3FF};
  logic [9:0]      e3 [4] = '{10'h3FF, 10'h0, 10'h3FF, 10'h3FF};
  int              n_errors = 0;
  int              comparisons = 0;

  always #2.5 clk = ~clk;

  logic_cluster u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF),
    .o_bvalid(bvalid), .i_bready(1'b1), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(1'b1), .o_rdata(rdata), .o_rresp(rresp),
    .i_row_clk(row_clk), .i_ctl(ctl), .i_chip_wide_reset_n(chip_rst_n), .i_cell_data(dat),
    .o_cell_row_a(row_a), .o_cell_row_b(row_b), .o_cell_local(loc), .o_lut_chain_out(lco),
    .o_reg_chain_out(rco), .o_carry_out(co));

  row_clock_source u_rows (.i_clk_sys(clk), .i_rst_b(rst_b), .i_req(req), .i_row(row),
    .i_slow(slow), .o_row_clk(row_clk), .o_done(done));

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    do begin
      @(posedge clk);
      if (awready === 1'b1) aw = 1'b1;
      if (wready === 1'b1) w = 1'b1;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!(aw && w));
    while (bvalid !== 1'b1) @(posedge clk);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic st(input logic [31:0] e);
    repeat (2) @(posedge clk);
    rd(`LC_ADDR_REG_STATE, e, OK);
  endtask

  task automatic lt(input logic [31:0] e);
    repeat (2) @(posedge clk);
    rd(`LC_ADDR_LUT_STATE, e, OK);
  endtask

  task automatic cfg(input int i, input cell_cfg_t c);
    wr(8'(`LC_ADDR_CELL_BASE + 4 * i), c, OK);
  endtask

  task automatic cfg_all(input cell_cfg_t c);
    for (int i = 0; i < 10; i++) cfg(i, c);
  endtask

  task automatic tog(input logic [2:0] r);
    req <= 1'b1;
    row <= r;
    do @(posedge clk); while (done !== 1'b1);
    req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic pul();
    tog(3'h0);
    tog(3'h0);
  endtask

  task automatic clr();
    ctl.clr_a <= 1'b1;
    @(posedge clk);
    ctl.clr_a <= 1'b0;
    @(posedge clk);
  endtask

  task automatic look();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    cell_cfg_t   c;
    logic [10:0] s;
    logic [9:0]  a;
    logic [9:0]  b;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`LC_ADDR_CTRL, `LC_CTRL_RESET, OK); // control reset
    wr(`LC_ADDR_CTRL, 32'hFFFF_FFFF, OK);
    rd(`LC_ADDR_CTRL, `LC_CTRL_MASK, OK); // control fields
    wr(`LC_ADDR_CTRL, 32'h0, OK);
    rd(`LC_ADDR_CELL_BASE, `LC_CELL_CFG_RESET, OK); // cell reset
    wr(8'h0C, 32'h1, ER); // hole refused
    rd(8'h0C, 32'h0, ER); // hole refused
    wr(8'h68, 32'h1, ER); // no eleventh cell
    wr(8'h64, 32'hA5A5_1234, OK);
    rd(8'h64, 32'hA5A5_1234, OK); // tenth cell
    // one pattern per cell
    for (int i = 0; i < 10; i++) begin
      c = '0;
      c.lut_mask = 16'h1 << i;
      cfg(i, c);
    end
    for (int k = 0; k < 16; k++) begin
      dat <= {10{4'(k)}};
      lt((k < 10) ? 32'h1 << k : 32'h0); // any function
      chk({22'h0, loc}, (k < 10) ? 32'h1 << k : 32'h0); // bypass
      chk({31'h0, lco}, {31'h0, k == 9}); // lookup chain end
    end
    c = '0;
    c.lut_mask = 16'hFF00;
    cfg_all(c);
    dat <= {10{4'h8}};
    pul();
    st(32'h0); // gate low
    ctl.gate_a <= 1'b1;
    pul();
    st(32'h3FF); // paired gate
    for (int m = 0; m < 4; m++) begin
      c.ff_mode = 2'(m);
      cfg_all(c);
      clr();
      dat <= {10{4'hC}};
      pul();
      pul();
      st({22'h0, e1[m]}); // modes
      dat <= {10{4'h0}};
      pul();
      st({22'h0, e2[m]}); // modes
      dat <= {10{4'h8}};
      pul();
      pul();
      st({22'h0, e3[m]}); // modes
    end
    c.ff_mode = 2'(FF_D);
    cfg_all(c);
    ctl.aload <= 1'b1;
    st(32'h3FF); // preset
    dat <= '0;
    st(32'h0); // load data from d
    dat <= {10{4'h8}};
    ctl.clr_a <= 1'b1;
    st(32'h0); // clear wins
    ctl.clr_a <= 1'b0;
    ctl.clr_b <= 1'b1;
    st(32'h3FF); // unselected clear
    ctl.clr_b <= 1'b0;
    ctl.aload <= 1'b0;
    chip_rst_n <= 1'b0;
    st(32'h3FF); // chip reset off
    chip_rst_n <= 1'b1;
    wr(`LC_ADDR_CTRL, 32'h80, OK);
    chip_rst_n <= 1'b0;
    st(32'h0); // chip reset on
    chip_rst_n <= 1'b1;
    dat <= {10{4'h4}};
    ctl.sload <= 1'b1;
    st(32'h0); // no edge no load
    pul();
    st(32'h3FF); // sync load
    ctl.sclr <= 1'b1;
    ctl.gate_a <= 1'b0;
    pul();
    st(32'h3FF); // gated off
    ctl.gate_a <= 1'b1;
    pul();
    st(32'h0); // clear before load
    ctl.sclr <= 1'b0;
    ctl.sload <= 1'b0;
    c.reg_chain = 1'b1;
    for (int i = 1; i < 10; i++) cfg(i, c);
    dat <= 40'h8;
    slow <= 1'b1;
    for (int k = 1; k <= 10; k++) begin
      pul();
      st((32'h1 << k) - 32'h1); // shift
      lt(32'h1); // unrelated lookup
    end
    chk({31'h0, rco}, 32'h1); // chain end
    slow <= 1'b0;
    clr();
    c = '0;
    c.lut_mask = 16'hFF00;
    c.pack_fb = 1'b1;
    cfg(0, c);
    c = '0;
    c.lut_mask = 16'hAAAA;
    c.lut_chain = 1'b1;
    cfg(1, c);
    dat <= {10{4'h8}};
    lt(32'h3FC); // own register fed back
    dat <= {10{4'hC}};
    ctl.sload <= 1'b1;
    pul();
    ctl.sload <= 1'b0;
    lt(32'h3FF); // lookup cascade
    clr();
    c = '0;
    c.lut_mask = 16'hFF00;
    c.out_reg = 3'b001;
    cfg(0, c);
    dat <= {10{4'h8}};
    look();
    chk({29'h0, row_a[0], row_b[0], loc[0]}, 32'h3); // mixed outputs
    @(posedge clk);
    pul();
    look();
    chk({29'h0, row_a[0], row_b[0], loc[0]}, 32'h7); // both forms
    @(posedge clk);
    c = '0;
    c.arith = 1'b1;
    cfg_all(c);
    a = 10'h2A5;
    b = 10'h0F3;
    for (int m = 0; m < 2; m++) begin
      ctl.addnsub <= m[0];
      for (int i = 0; i < 10; i++) dat[i] <= {2'b00, b[i], a[i]}; // bit 0 in cell 0
      s = {1'b0, a} + {1'b0, b ^ {10{m[0]}}} + 11'(m);
      lt({22'h0, s[9:0]}); // add or subtract
      look();
      chk({31'h0, co}, {31'h0, s[10]}); // carry out
      @(posedge clk);
    end
    clr();
    wr(`LC_ADDR_CTRL, 32'h48, OK);
    c = '0;
    c.lut_mask = 16'hFF00;
    c.clk_sel_b = 1'b1;
    cfg_all(c);
    dat <= {10{4'h8}};
    ctl.gate_b <= 1'b1;
    tog(3'h1);
    st(32'h0); // rising ignored
    tog(3'h1);
    st(32'h3FF); // falling edge clock
    c.lut_mask = 16'hCCCC;
    c.local_in = 1'b1;
    cfg(0, c);
    lt(32'h3FF); // neighbour's local output
    dat[1] <= 4'h0;
    lt(32'h3FC); // local routing inside cluster
    summarize();
  end
endmodule
`default_nettype wire
